/* File: shared/mailbox_pkg.sv */
// Constants, register map and state type for the synthesizer configuration mailbox.
// Assumes a byte-wide register port on one clock; multi-byte registers are most significant byte first.
// Notes on behaviour
// [RULE_01] Fetch request loads masked synthesizer into page.
// [RULE_02] Host sets exactly one mask bit for fetch.
// [RULE_03] Semaphore reads zero once fetch completes.
// [RULE_04] Page holds fetched configuration after completion.
// [RULE_05] Apply starts only when fetch bit zero.
// [RULE_06] Apply copies page to every masked synthesizer.
// [RULE_07] Apply completion clears the semaphore to zero.
// [RULE_08] Base frequency 16 bits, reset 0x1F40.
// [RULE_09] Frequency is base times multiplier times numerator/denominator.
// [RULE_10] Multiplier 24 bits, reset 0x017BB0.
// [RULE_11] Numerator 16 bits, reset 0x0001.
// [RULE_12] Semaphore upper six bits read zero.
// [RULE_13] Ten-bit mask, bits 0-3 pick synthesizers.
// [RULE_14] Denominator 16 bits, reset one.
// [RULE_15] Host leaves page alone while request pending.
`default_nettype none

package mailbox_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] MASK_ADDR = 16'h0682;
    localparam logic [15:0] SEM_ADDR  = 16'h0684;
    localparam logic [15:0] BASE_ADDR = 16'h0685;
    localparam logic [15:0] MULT_ADDR = 16'h0687;
    localparam logic [15:0] NUM_ADDR  = 16'h068A;
    localparam logic [15:0] DEN_ADDR  = 16'h068C;

    // ------------------------------------------------------------------
    // Field widths and positions
    // ------------------------------------------------------------------
    localparam int SEM_APPLY_BIT   = 0;
    localparam int SEM_FETCH_BIT   = 1;
    localparam int MASK_WIDTH      = 10;
    localparam int SYNTH_COUNT     = 4;
    localparam int SYNTH_IDX_WIDTH = 2;
    localparam int BASE_WIDTH      = 16;
    localparam int MULT_WIDTH      = 24;
    localparam int NUM_WIDTH       = 16;
    localparam int DEN_WIDTH       = 16;
    localparam int CFG_WIDTH       = BASE_WIDTH + MULT_WIDTH + NUM_WIDTH + DEN_WIDTH;
    localparam int CFG_DEN_LSB     = 0;
    localparam int CFG_NUM_LSB     = CFG_DEN_LSB + DEN_WIDTH;
    localparam int CFG_MULT_LSB    = CFG_NUM_LSB + NUM_WIDTH;
    localparam int CFG_BASE_LSB    = CFG_MULT_LSB + MULT_WIDTH;
    localparam int PRODUCT_WIDTH   = BASE_WIDTH + MULT_WIDTH + NUM_WIDTH;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]            SEM_RESET  = 8'h00;
    localparam logic [MASK_WIDTH-1:0] MASK_RESET = 10'h001;
    localparam logic [BASE_WIDTH-1:0] BASE_RESET = 16'h1f40;
    localparam logic [MULT_WIDTH-1:0] MULT_RESET = 24'h01_7bb0;
    localparam logic [NUM_WIDTH-1:0]  NUM_RESET  = 16'h0001;
    localparam logic [DEN_WIDTH-1:0]  DEN_RESET  = 16'h0001;
    localparam logic [CFG_WIDTH-1:0]  CFG_RESET  = {BASE_RESET, MULT_RESET, NUM_RESET, DEN_RESET};

    // Clock cycles one frequency calculation takes after its start.
    localparam int CALC_CYCLES = PRODUCT_WIDTH + 1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH_READ,
        ST_FETCH_LOAD,
        ST_APPLY,
        ST_DONE
    } mbox_state_type;

endpackage

`default_nettype wire

/* File: design/synth_store.sv */
// Stored configuration words, one per synthesizer, with a registered read port.
// Assumes one writer and one reader on the same clock; entries reset to the default configuration.
`timescale 1ns/10ps
`default_nettype none

module synth_store
    import mailbox_pkg::*;
#(
    parameter int                   DEPTH       = SYNTH_COUNT,
    parameter int                   WIDTH       = CFG_WIDTH,
    parameter logic [WIDTH-1:0]     RESET_VALUE = CFG_RESET
) (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic                       we,
    input  wire logic [$clog2(DEPTH)-1:0]   waddr,
    input  wire logic [WIDTH-1:0]           wdata,
    input  wire logic [$clog2(DEPTH)-1:0]   raddr,
    output logic      [WIDTH-1:0]           rdata
);

    logic [WIDTH-1:0] entry_reg [DEPTH];

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_entry
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    entry_reg[g] <= RESET_VALUE;
                end else if (we && (waddr == ($clog2(DEPTH))'(g))) begin
                    entry_reg[g] <= wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= RESET_VALUE;
        end else begin
            rdata <= entry_reg[raddr];
        end
    end

endmodule // synth_store

`default_nettype wire

/* File: design/osc_freq_calc.sv */
// Sequential calculation of the oscillator frequency from the four page terms.
// Assumes start is a one-cycle pulse; a new start abandons any calculation in flight.
`timescale 1ns/10ps
`default_nettype none

module osc_freq_calc
    import mailbox_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire logic                     start,
    input  wire logic [BASE_WIDTH-1:0]    base_frequency_term,
    input  wire logic [MULT_WIDTH-1:0]    multiplier_term,
    input  wire logic [NUM_WIDTH-1:0]     numerator_term,
    input  wire logic [DEN_WIDTH-1:0]     denominator_term,
    output logic      [PRODUCT_WIDTH-1:0] freq_hz,
    output logic                          freq_valid
);

    localparam int CNT_WIDTH = $clog2(PRODUCT_WIDTH + 1);

    logic [PRODUCT_WIDTH-1:0] quot_reg;
    logic [DEN_WIDTH-1:0]     rem_reg;
    logic [DEN_WIDTH-1:0]     den_reg;
    logic [CNT_WIDTH-1:0]     count_reg;
    logic                     running_reg;
    logic [DEN_WIDTH:0]       trial;
    logic                     fits;

    // Restoring division, one quotient bit per clock.
    assign trial = {rem_reg, quot_reg[PRODUCT_WIDTH-1]};
    assign fits  = trial >= {1'b0, den_reg};

    // [RULE_09] Product over denominator
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            quot_reg    <= '0;
            rem_reg     <= '0;
            den_reg     <= DEN_RESET;
            count_reg   <= '0;
            running_reg <= 1'b0;
        end else if (start) begin
            quot_reg    <= PRODUCT_WIDTH'(base_frequency_term) * PRODUCT_WIDTH'(multiplier_term)
                           * PRODUCT_WIDTH'(numerator_term);
            rem_reg     <= '0;
            den_reg     <= denominator_term;
            count_reg   <= CNT_WIDTH'(PRODUCT_WIDTH);
            running_reg <= 1'b1;
        end else if (running_reg) begin
            rem_reg     <= fits ? DEN_WIDTH'(trial - {1'b0, den_reg}) : trial[DEN_WIDTH-1:0];
            quot_reg    <= {quot_reg[PRODUCT_WIDTH-2:0], fits};
            count_reg   <= count_reg - 1'b1;
            running_reg <= (count_reg != CNT_WIDTH'(1));
        end
    end

    // A zero denominator yields all ones, the natural result of the divider.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            freq_hz    <= '0;
            freq_valid <= 1'b0;
        end else if (start) begin
            freq_valid <= 1'b0;
        end else if (running_reg && count_reg == CNT_WIDTH'(1)) begin
            freq_hz    <= {quot_reg[PRODUCT_WIDTH-2:0], fits};
            freq_valid <= 1'b1;
        end
    end

endmodule // osc_freq_calc

`default_nettype wire

/* File: design/synth_config_mailbox.sv */
// Mailbox page for synthesizer configuration: request flags, frequency terms and selection mask.
// Assumes a byte register port on clk; reads answer one cycle after reg_rd.
`timescale 1ns/10ps
`default_nettype none

module synth_config_mailbox
    import mailbox_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire logic [15:0]              reg_addr,
    input  wire logic                     reg_wr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_rd,
    output logic      [7:0]               reg_rdata,
    output logic      [PRODUCT_WIDTH-1:0] osc_freq_hz,
    output logic                          osc_freq_valid
);

    // ------------------------------------------------------------------
    // Page registers
    // ------------------------------------------------------------------
    logic [MASK_WIDTH-1:0]      mask_reg;
    logic                       sem_fetch_reg;
    logic                       sem_apply_reg;
    logic [BASE_WIDTH-1:0]      base_frequency_term_reg;
    logic [MULT_WIDTH-1:0]      multiplier_term_reg;
    logic [NUM_WIDTH-1:0]       numerator_term_reg;
    logic [DEN_WIDTH-1:0]       denominator_term_reg;
    logic                       recalc_reg;

    mbox_state_type             state_reg;
    mbox_state_type             state_next;
    logic [SYNTH_IDX_WIDTH-1:0] sel_idx_reg;
    logic [SYNTH_IDX_WIDTH-1:0] sel_idx_next;
    logic                       sel_hit;
    logic [SYNTH_IDX_WIDTH-1:0] apply_idx_reg;

    logic                       mem_we;
    logic [CFG_WIDTH-1:0]       page_cfg;
    logic [CFG_WIDTH-1:0]       mem_rdata;
    logic                       page_load;
    logic                       page_write;
    logic                       sem_write;
    logic                       sem_idle;
    logic [7:0]                 rd_mux;

    assign page_cfg   = {base_frequency_term_reg, multiplier_term_reg, numerator_term_reg, denominator_term_reg};
    assign page_load  = (state_reg == ST_FETCH_LOAD);
    assign sem_idle   = (state_reg == ST_IDLE) && !sem_fetch_reg && !sem_apply_reg;
    assign sem_write  = reg_wr && (reg_addr == SEM_ADDR);
    assign page_write = reg_wr && (reg_addr >= BASE_ADDR) && (reg_addr <= DEN_ADDR + 16'h0001);

    // ------------------------------------------------------------------
    // Request flags
    // ------------------------------------------------------------------
    // A request is accepted only while the mailbox is idle, so a completion clear can never meet a new set.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sem_fetch_reg <= SEM_RESET[SEM_FETCH_BIT];
            sem_apply_reg <= SEM_RESET[SEM_APPLY_BIT];
        end else if (state_reg == ST_DONE) begin
            // [RULE_03] [RULE_07] Completion clears semaphore
            sem_fetch_reg <= 1'b0;
            sem_apply_reg <= 1'b0;
        end else if (sem_write && sem_idle) begin
            sem_fetch_reg <= reg_wdata[SEM_FETCH_BIT];
            // [RULE_05] Apply needs fetch clear
            sem_apply_reg <= reg_wdata[SEM_APPLY_BIT] && !reg_wdata[SEM_FETCH_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Selection mask and frequency terms
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_reg <= MASK_RESET;
        end else if (reg_wr && reg_addr == MASK_ADDR) begin
            mask_reg[MASK_WIDTH-1:8] <= reg_wdata[MASK_WIDTH-9:0];
        end else if (reg_wr && reg_addr == MASK_ADDR + 16'h0001) begin
            mask_reg[7:0] <= reg_wdata;
        end
    end

    // A fetch load wins over a host write in the same cycle.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // [RULE_08] Base term reset
            base_frequency_term_reg <= BASE_RESET;
            // [RULE_10] Multiplier term reset
            multiplier_term_reg     <= MULT_RESET;
            // [RULE_11] Numerator term reset
            numerator_term_reg      <= NUM_RESET;
            // [RULE_14] Denominator term reset
            denominator_term_reg    <= DEN_RESET;
        end else if (page_load) begin
            // [RULE_01] [RULE_04] Load fetched configuration
            base_frequency_term_reg <= mem_rdata[CFG_BASE_LSB +: BASE_WIDTH];
            multiplier_term_reg     <= mem_rdata[CFG_MULT_LSB +: MULT_WIDTH];
            numerator_term_reg      <= mem_rdata[CFG_NUM_LSB +: NUM_WIDTH];
            denominator_term_reg    <= mem_rdata[CFG_DEN_LSB +: DEN_WIDTH];
        end else if (reg_wr) begin
            unique case (reg_addr)
                BASE_ADDR:           base_frequency_term_reg[15:8] <= reg_wdata;
                BASE_ADDR + 16'h1:   base_frequency_term_reg[7:0]  <= reg_wdata;
                MULT_ADDR:           multiplier_term_reg[23:16]    <= reg_wdata;
                MULT_ADDR + 16'h1:   multiplier_term_reg[15:8]     <= reg_wdata;
                MULT_ADDR + 16'h2:   multiplier_term_reg[7:0]      <= reg_wdata;
                NUM_ADDR:            numerator_term_reg[15:8]      <= reg_wdata;
                NUM_ADDR + 16'h1:    numerator_term_reg[7:0]       <= reg_wdata;
                DEN_ADDR:            denominator_term_reg[15:8]    <= reg_wdata;
                DEN_ADDR + 16'h1:    denominator_term_reg[7:0]     <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // The calculation restarts one cycle after any change of the terms, and once after reset.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            recalc_reg <= 1'b1;
        end else begin
            recalc_reg <= page_load || page_write;
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_addr)
            MASK_ADDR:           rd_mux = 8'(mask_reg[MASK_WIDTH-1:8]);
            MASK_ADDR + 16'h1:   rd_mux = mask_reg[7:0];
            // [RULE_12] Reserved bits zero
            SEM_ADDR:            rd_mux = {6'h00, sem_fetch_reg, sem_apply_reg};
            BASE_ADDR:           rd_mux = base_frequency_term_reg[15:8];
            BASE_ADDR + 16'h1:   rd_mux = base_frequency_term_reg[7:0];
            MULT_ADDR:           rd_mux = multiplier_term_reg[23:16];
            MULT_ADDR + 16'h1:   rd_mux = multiplier_term_reg[15:8];
            MULT_ADDR + 16'h2:   rd_mux = multiplier_term_reg[7:0];
            NUM_ADDR:            rd_mux = numerator_term_reg[15:8];
            NUM_ADDR + 16'h1:    rd_mux = numerator_term_reg[7:0];
            DEN_ADDR:            rd_mux = denominator_term_reg[15:8];
            DEN_ADDR + 16'h1:    rd_mux = denominator_term_reg[7:0];
            default:             rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // Mailbox sequencer
    // ------------------------------------------------------------------
    // [RULE_02] [RULE_13] Lowest selected synthesizer fetched
    always_comb begin
        sel_idx_next = '0;
        sel_hit      = 1'b0;
        for (int i = SYNTH_COUNT - 1; i >= 0; i--) begin
            if (mask_reg[i]) begin
                sel_idx_next = SYNTH_IDX_WIDTH'(i);
                sel_hit      = 1'b1;
            end
        end
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (sem_fetch_reg) begin
                    state_next = sel_hit ? ST_FETCH_READ : ST_DONE;
                end else if (sem_apply_reg) begin
                    state_next = ST_APPLY;
                end
            end
            ST_FETCH_READ: state_next = ST_FETCH_LOAD;
            ST_FETCH_LOAD: state_next = ST_DONE;
            ST_APPLY: begin
                if (apply_idx_reg == SYNTH_IDX_WIDTH'(SYNTH_COUNT - 1)) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE:       state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_idx_reg   <= '0;
            apply_idx_reg <= '0;
        end else begin
            if (state_reg == ST_IDLE) begin
                sel_idx_reg <= sel_idx_next;
            end
            apply_idx_reg <= (state_reg == ST_APPLY) ? apply_idx_reg + 1'b1 : '0;
        end
    end

    // [RULE_06] Write page to masked synthesizers
    assign mem_we = (state_reg == ST_APPLY) && mask_reg[apply_idx_reg];

    synth_store #(
        .DEPTH       (SYNTH_COUNT),
        .WIDTH       (CFG_WIDTH),
        .RESET_VALUE (CFG_RESET)
    ) u_store (
        .clk   (clk),
        .rst_b (rst_b),
        .we    (mem_we),
        .waddr (apply_idx_reg),
        .wdata (page_cfg),
        .raddr (sel_idx_reg),
        .rdata (mem_rdata)
    );

    // [RULE_09] Oscillator frequency
    osc_freq_calc u_calc (
        .clk                 (clk),
        .rst_b               (rst_b),
        .start               (recalc_reg),
        .base_frequency_term (base_frequency_term_reg),
        .multiplier_term     (multiplier_term_reg),
        .numerator_term      (numerator_term_reg),
        .denominator_term    (denominator_term_reg),
        .freq_hz             (osc_freq_hz),
        .freq_valid          (osc_freq_valid)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_FETCH_LOADS_PAGE: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_01]
        state_reg == ST_FETCH_LOAD |=> page_cfg == $past(mem_rdata))
        else $error("Fetch did not load the page from the selected synthesizer.");

    AST_FETCH_COMPLETES: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_03]
        $rose(sem_fetch_reg) |-> sem_fetch_reg [*2] ##[1:4] !sem_fetch_reg && !sem_apply_reg)
        else $error("Fetch request did not clear within the expected time.");

    AST_PAGE_STABLE_AFTER_FETCH: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_04]
        state_reg == ST_DONE && $past(state_reg) == ST_FETCH_LOAD |-> page_cfg == mem_rdata)
        else $error("Page differs from the fetched synthesizer at completion.");

    AST_APPLY_NOT_WITH_FETCH: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_05]
        $rose(sem_apply_reg) |-> !sem_fetch_reg ##1 state_reg == ST_APPLY)
        else $error("Apply started while a fetch was requested or did not start.");

    AST_APPLY_WRITES_MASKED: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_06]
        $rose(state_reg == ST_APPLY) |-> mem_we == mask_reg[0] ##1 mem_we == mask_reg[1]
            ##1 mem_we == mask_reg[2] ##1 mem_we == mask_reg[3])
        else $error("Apply write enable does not follow the mask.");

    AST_APPLY_VISITS_ALL: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_06]
        $rose(state_reg == ST_APPLY) |-> apply_idx_reg == 2'h0 ##3 apply_idx_reg == 2'h3 ##1 state_reg == ST_DONE)
        else $error("Apply did not walk all four synthesizers.");

    AST_APPLY_CLEARS_SEM: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_07]
        $rose(sem_apply_reg) |-> (sem_apply_reg throughout (##[5:6] (state_reg == ST_DONE))) ##1 !sem_apply_reg)
        else $error("Apply did not clear the semaphore on completion.");

    AST_SEM_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_12]
        reg_rd && reg_addr == SEM_ADDR |=> reg_rdata[7:2] == 6'h00)
        else $error("Reserved semaphore bits read as nonzero.");

endmodule // synth_config_mailbox

`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the synthesizer configuration mailbox.
// Assumes the byte register port of the design top and the package constants.
`timescale 1ns/10ps
`default_nettype none

module testbench
    import mailbox_pkg::*;
;
    logic                     clk;
    logic                     rst_b;
    logic [15:0]              reg_addr;
    logic                     reg_wr;
    logic [7:0]               reg_wdata;
    logic                     reg_rd;
    logic [7:0]               reg_rdata;
    logic [PRODUCT_WIDTH-1:0] osc_freq_hz;
    logic                     osc_freq_valid;
    int                       mismatches;
    int                       compares;
    int                       i;

    synth_config_mailbox i_synth_config_mailbox (
        .clk            (clk),
        .rst_b          (rst_b),
        .reg_addr       (reg_addr),
        .reg_wr         (reg_wr),
        .reg_wdata      (reg_wdata),
        .reg_rd         (reg_rd),
        .reg_rdata      (reg_rdata),
        .osc_freq_hz    (osc_freq_hz),
        .osc_freq_valid (osc_freq_valid)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t byte got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_freq(input logic [PRODUCT_WIDTH-1:0] exp);
        compares++;
        if (osc_freq_hz !== exp) begin
            mismatches++;
            $display("BAD %0t frequency got %h expected %h", $time, osc_freq_hz, exp);
        end
    endtask

    task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
    endtask

    task automatic rd_byte(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        d      = reg_rdata;
    endtask

    task automatic wr_reg(input logic [15:0] a, input int n, input logic [31:0] v);
        for (int k = 0; k < n; k++) begin
            wr_byte(a + 16'(k), v[8*(n-1-k)+:8]);
        end
    endtask

    task automatic exp_reg(input logic [15:0] a, input int n, input logic [31:0] v);
        logic [7:0] d;
        for (int k = 0; k < n; k++) begin
            rd_byte(a + 16'(k), d);
            chk_byte(d, v[8*(n-1-k)+:8]);
        end
    endtask

    // The first poll must still see a request bit; then poll until zero.
    task automatic wait_idle();
        logic [7:0] s;
        rd_byte(SEM_ADDR, s);
        chk_byte({7'h00, |s[1:0]}, 8'h01);
        for (int k = 0; k < 50 && s !== 8'h00; k++) begin
            rd_byte(SEM_ADDR, s);
        end
        chk_byte(s, 8'h00);
        if (s !== 8'h00) begin
            summarize();
        end
    endtask

    task automatic wait_freq(input logic [PRODUCT_WIDTH-1:0] exp);
        int k;
        repeat (3) @(posedge clk);
        #1;
        for (k = 0; k < 200 && osc_freq_valid !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        if (k == 200) begin
            mismatches++;
            $display("BAD %0t frequency never valid", $time);
            summarize();
        end
        chk_freq(exp);
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        rst_b      = 1'b0;
        reg_addr   = 16'h0000;
        reg_wr     = 1'b0;
        reg_wdata  = 8'h00;
        reg_rd     = 1'b0;
        mismatches = 0;
        compares   = 0;
        repeat (20) @(posedge clk);
        #1;
        rst_b = 1'b1;
        exp_reg(SEM_ADDR, 1, 32'h0000_0000);
        exp_reg(MASK_ADDR, 2, 32'h0000_0001);
        exp_reg(BASE_ADDR, 2, 32'h0000_1f40);
        exp_reg(MULT_ADDR, 3, 32'h0001_7bb0);
        exp_reg(NUM_ADDR, 2, 32'h0000_0001);
        exp_reg(DEN_ADDR, 2, 32'h0000_0001);
        wait_freq(56'h00_0000_2e59_3c00);
        wr_reg(SEM_ADDR, 1, 32'h0000_00fc);
        exp_reg(SEM_ADDR, 1, 32'h0000_0000);
        $display("test reset_values done");
        wr_reg(BASE_ADDR, 2, 32'h0000_61a8);
        wr_reg(MULT_ADDR, 3, 32'h0001_86a0);
        wr_reg(MASK_ADDR, 2, 32'h0000_0006);
        exp_reg(MASK_ADDR, 2, 32'h0000_0006);
        wr_reg(SEM_ADDR, 1, 32'h0000_0001);
        wait_idle();
        wr_reg(BASE_ADDR, 2, 32'h0000_1234);
        $display("test apply done");
        for (i = 0; i < 4; i++) begin
            wr_reg(MASK_ADDR, 2, 32'(1) << i);
            wr_reg(SEM_ADDR, 1, 32'h0000_0002);
            wait_idle();
            exp_reg(BASE_ADDR, 2, (i == 1 || i == 2) ? 32'h0000_61a8 : 32'h0000_1f40);
            exp_reg(MULT_ADDR, 3, (i == 1 || i == 2) ? 32'h0001_86a0 : 32'h0001_7bb0);
        end
        wr_reg(MASK_ADDR, 2, 32'h0000_0004);
        wr_reg(SEM_ADDR, 1, 32'h0000_0003);
        wait_idle();
        exp_reg(BASE_ADDR, 2, 32'h0000_61a8);
        wr_reg(MASK_ADDR, 2, 32'h0000_0200);
        exp_reg(MASK_ADDR, 2, 32'h0000_0200);
        wr_reg(SEM_ADDR, 1, 32'h0000_0002);
        wait_idle();
        exp_reg(BASE_ADDR, 2, 32'h0000_61a8);
        $display("test fetch done");
        wait_freq(56'h00_0000_9502_f900);
        wr_reg(DEN_ADDR, 2, 32'h0000_0002);
        exp_reg(DEN_ADDR, 2, 32'h0000_0002);
        wait_freq(56'h00_0000_4a81_7c80);
        wr_reg(NUM_ADDR, 2, 32'h0000_0003);
        exp_reg(NUM_ADDR, 2, 32'h0000_0003);
        wait_freq(56'h00_0000_df84_7580);
        $display("test frequency done");
        summarize();
    end

endmodule // testbench

`default_nettype wire
